// File: core/lefm_top.sv
/*
 * Event flag register, enable mask, diagnostic write mode and the asynchronous
 * transmit stuck state, reached over an AXI4-Lite slave.
 * Assumes event inputs are one-cycle pulses from logic on clk.
 */
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
module lefm_top (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Event pulses from the link
	input  wire logic        ev_phy_irq,
	input  wire logic        ev_phy_reg_rx,
	input  wire logic        ev_bus_reset,
	input  wire logic        ev_tx_idle,
	input  wire logic        ev_async_rx,
	input  wire logic        ev_reset_cmd,
	input  wire logic        ev_iso_rx,
	input  wire logic        ev_selfid_err,
	input  wire logic        ev_iso_tx_bad,
	input  wire logic        ev_async_underflow,
	input  wire logic        ev_async_bad_first,
	input  wire logic        ev_busy_ack,
	input  wire logic        ev_header_crc,
	input  wire logic        ev_bad_tcode,
	input  wire logic        ev_host_wr_err,
	input  wire logic        async_tx_queue_clear,
	// Outputs
	output logic             irq,
	output logic             async_tx_stuck_state,
	output logic             async_tx_allow
);
	import lefm_pkg::*;

	// Big-endian position to one-hot vector mask.
	function automatic logic [31:0] lefm_bit(input int pos);
		lefm_bit = 32'h8000_0000 >> pos;
	endfunction : lefm_bit

	localparam int SRC_POS [LEFM_NSRC] = '{LEFM_POS_PHY, LEFM_POS_PREG, LEFM_POS_BRST,
		LEFM_POS_TRANSMITTER_IDLE_FLAG, LEFM_POS_ARX, LEFM_POS_CMD, LEFM_POS_IRX, LEFM_POS_SID,
		LEFM_POS_ITS, LEFM_POS_ATS, LEFM_POS_BUSY, LEFM_POS_HCRC, LEFM_POS_TCE,
		LEFM_POS_HWE, LEFM_POS_SUM};

	logic [31:0] flags_r;
	logic [31:0] flags_nxt;
	logic [31:0] mask_r;
	logic [31:0] diag_r;
	logic        stuck_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        aw_have_r;
	logic        w_have_r;
	logic        irq_r;
	logic        allow_r;

	wire [31:0] impl_bits;
	wire [31:0] hw_set;
	wire [LEFM_NSRC-2:0] ev_vec;
	wire [31:0] wr_bytes;
	wire        wr_fire;
	wire        wr_flags;
	wire        wr_mask;
	wire        wr_diag;
	wire        wr_ok;
	wire        diag_mode;
	wire        rd_fire;
	wire        rd_ok;
	wire [31:0] rd_val;
	wire        sum_nxt;
	wire        stuck_set;
	wire        stuck_nxt;
	wire        rd_hit_flags;
	wire        rd_hit_mask;
	wire        rd_hit_diag;
	wire        rd_hit_stat;

	assign ev_vec = {ev_host_wr_err, ev_bad_tcode, ev_header_crc, ev_busy_ack,
		ev_async_underflow | ev_async_bad_first, ev_iso_tx_bad, ev_selfid_err,
		ev_iso_rx, ev_reset_cmd, ev_async_rx, ev_tx_idle, ev_bus_reset,
		ev_phy_reg_rx, ev_phy_irq};

	// Implemented positions; reserved ones stay zero.
	genvar gi;
	generate
		for (gi = 0; gi < LEFM_NSRC - 1; gi++) begin : g_src
			// R8 R9 R10 R11 R12 R13 R14 R15 R16 R17 R18 R19 R20 R21 - event to flag.
			assign hw_set[31-SRC_POS[gi]] = ev_vec[gi];
		end
	endgenerate
	assign hw_set[31] = 1'b0;
	assign hw_set[27] = 1'b0;
	assign hw_set[23] = 1'b0;
	assign hw_set[18] = 1'b0;
	assign hw_set[14:13] = 2'b00;
	assign hw_set[11:0] = 12'h000;

	// R22 implemented positions; reserved ones read zero.
	assign impl_bits = lefm_bit(LEFM_POS_PHY) | lefm_bit(LEFM_POS_PREG)
		| lefm_bit(LEFM_POS_BRST) | lefm_bit(LEFM_POS_TRANSMITTER_IDLE_FLAG) | lefm_bit(LEFM_POS_ARX)
		| lefm_bit(LEFM_POS_CMD) | lefm_bit(LEFM_POS_IRX) | lefm_bit(LEFM_POS_SID)
		| lefm_bit(LEFM_POS_ITS) | lefm_bit(LEFM_POS_ATS) | lefm_bit(LEFM_POS_BUSY)
		| lefm_bit(LEFM_POS_HCRC) | lefm_bit(LEFM_POS_TCE) | lefm_bit(LEFM_POS_HWE);

	assign wr_fire  = aw_have_r && w_have_r && !s_axi_bvalid;
	assign wr_bytes = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	assign wr_flags = wr_fire && (awaddr_r == LEFM_OFS_FLAGS);
	assign wr_mask  = wr_fire && (awaddr_r == LEFM_OFS_MASK);
	assign wr_diag  = wr_fire && (awaddr_r == LEFM_OFS_DIAG);
	assign wr_ok    = wr_flags || wr_mask || wr_diag
		|| (awaddr_r == LEFM_OFS_STAT);
	assign diag_mode = diag_r[31-LEFM_POS_DIAG];

	// R1 R5 R7 summary: mask gates each flag; diagnostic mode stops normal summary.
	assign sum_nxt = !diag_mode && |(flags_nxt & mask_r & impl_bits);

	always_comb begin
		flags_nxt = flags_r & impl_bits;
		if (wr_flags && diag_mode) begin
			// R4 direct set in test mode.
			flags_nxt = flags_nxt | (wdata_r & wr_bytes & (impl_bits | lefm_bit(0)));
		end else if (wr_flags) begin
			// R3 write one to clear.
			flags_nxt = flags_nxt & ~(wdata_r & wr_bytes);
		end
		// R2 events set regardless of mask; set wins over clear.
		flags_nxt = flags_nxt | hw_set;
		if (diag_mode) begin
			flags_nxt[31-LEFM_POS_SUM] = flags_nxt[31-LEFM_POS_SUM]
				| (flags_r[31-LEFM_POS_SUM] & !(wr_flags & !diag_mode));
		end else begin
			flags_nxt[31-LEFM_POS_SUM] = |(flags_nxt & mask_r & impl_bits);
		end
	end

	// R17 stuck state.
	assign stuck_set = ev_async_underflow | ev_async_bad_first;
	// R17 set beats clear.
	assign stuck_nxt = stuck_set || (stuck_r && !async_tx_queue_clear);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			flags_r <= 32'h0000_0000;
			// R6 mask reset value.
			mask_r  <= LEFM_MASK_RST;
			diag_r  <= LEFM_DIAG_RST;
			stuck_r <= 1'b0;
			allow_r <= 1'b1;
		end else begin
			flags_r <= flags_nxt;
			if (wr_mask)
				mask_r <= (mask_r & ~wr_bytes) | (wdata_r & wr_bytes);
			if (wr_diag)
				diag_r <= (diag_r & ~wr_bytes) | (wdata_r & wr_bytes & lefm_bit(LEFM_POS_DIAG));
			// R17 stuck and permit flops.
			stuck_r <= stuck_nxt;
			allow_r <= !stuck_nxt;
		end
	end

	// R23 interrupt output, registered from the summary.
	always_ff @(posedge clk) begin
		if (!resetn)
			irq_r <= 1'b0;
		else
			irq_r <= diag_mode ? flags_nxt[31-LEFM_POS_SUM] : sum_nxt;
	end
	assign irq = irq_r;
	assign async_tx_stuck_state = stuck_r;
	// R17 asynchronous sends held while stuck.
	// A flop of its own keeps this output glitch free for the transmitter.
	assign async_tx_allow = allow_r;

	// Write channel capture; address and data may come in either order.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			aw_have_r    <= 1'b0;
			w_have_r     <= 1'b0;
			awaddr_r     <= 8'h00;
			wdata_r      <= 32'h0000_0000;
			wstrb_r      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= LEFM_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? LEFM_RESP_OKAY : LEFM_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready  <= !w_have_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
		end
	end

	// Read channel: one outstanding read, answered the cycle after the address.
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_hit_flags = (s_axi_araddr[7:2] == LEFM_OFS_FLAGS[7:2]);
	assign rd_hit_mask  = (s_axi_araddr[7:2] == LEFM_OFS_MASK[7:2]);
	assign rd_hit_diag  = (s_axi_araddr[7:2] == LEFM_OFS_DIAG[7:2]);
	assign rd_hit_stat  = (s_axi_araddr[7:2] == LEFM_OFS_STAT[7:2]);
	assign rd_ok   = rd_hit_flags || rd_hit_mask || rd_hit_diag || rd_hit_stat;
	assign rd_val  = rd_hit_flags ? flags_r
		: rd_hit_mask ? mask_r
		: rd_hit_diag ? diag_r
		: rd_hit_stat ? {stuck_r, 31'h0000_0000}
		: 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= LEFM_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_fire;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= rd_ok ? LEFM_RESP_OKAY : LEFM_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : lefm_top

// File: include/lefm_pkg.sv
/*
 * Package for the link event flag and mask unit: register offsets, bit positions of
 * every event flag, reset values and the AXI4-Lite response codes.
 * Assumes big-endian bit numbering: position n lives at vector index 31-n.
 */
// Overview of operation
// R1 - Each flag is a separate source; mask bit zero blocks it from the interrupt.
// R2 - Flags record and read back regardless of their mask bit.
// R3 - Writing one to a flag clears it; writing zero leaves it unchanged.
// R4 - With diagnostic write bit set, writes set any flag, bit 0 included; mask ignored.
// R5 - Software must clear the diagnostic write bit after testing, else no interrupts.
// R6 - Mask resets to enable only summary and host write protocol error, fully RW.
// R7 - Bit 0 is the OR of all flags qualified by their mask bits.
// R8 - Bit 1 sets when the physical layer signals an interrupt.
// R9 - Bit 2 sets when a physical layer register value reaches the access register.
// R10 - Bit 3 sets when a bus reset reconfiguration starts.
// R11 - Bit 5 sets when the transmitter becomes idle and ready.
// R12 - Bit 6 sets when asynchronous receive data is confirmed.
// R13 - Bit 9 sets when isochronous receive data is confirmed.
// R14 - Bit 7 sets on a quadlet write to the reset start register.
// R15 - Bit 10 sets on a received self identification error.
// R16 - Bit 11 sets on invalid data at the isochronous transmit queue.
// R17 - Bit 12 sets and stuck state entered on underflow or bad first entry; clear releases.
// R18 - Bit 14 sets when a busy acknowledge was sent on receive queue overflow.
// R19 - Bit 15 sets on a header CRC error for a possibly local packet.
// R20 - Bit 16 sets on an invalid transaction code at the transmit queue.
// R21 - Bit 19 sets when the host violates the quadlet write protocol.
// R22 - Big-endian bit numbering; reserved positions 4, 8, 13, 17, 18 read zero.
// R23 - Interrupt output follows the summary bit.
package lefm_pkg;
	localparam logic [7:0]  LEFM_OFS_FLAGS = 8'h0C;
	localparam logic [7:0]  LEFM_OFS_MASK  = 8'h10;
	localparam logic [7:0]  LEFM_OFS_DIAG  = 8'h20;
	localparam logic [7:0]  LEFM_OFS_STAT  = 8'h40;
	localparam logic [31:0] LEFM_MASK_RST  = 32'h8000_1000;
	localparam logic [31:0] LEFM_DIAG_RST  = 32'h0000_0000;
	localparam int LEFM_POS_SUM   = 0;
	localparam int LEFM_POS_PHY   = 1;
	localparam int LEFM_POS_PREG  = 2;
	localparam int LEFM_POS_BRST  = 3;
	localparam int LEFM_POS_TRANSMITTER_IDLE_FLAG = 5;
	localparam int LEFM_POS_ARX   = 6;
	localparam int LEFM_POS_CMD   = 7;
	localparam int LEFM_POS_IRX   = 9;
	localparam int LEFM_POS_SID   = 10;
	localparam int LEFM_POS_ITS   = 11;
	localparam int LEFM_POS_ATS   = 12;
	localparam int LEFM_POS_BUSY  = 14;
	localparam int LEFM_POS_HCRC  = 15;
	localparam int LEFM_POS_TCE   = 16;
	localparam int LEFM_POS_HWE   = 19;
	localparam int LEFM_POS_DIAG  = 0;
	localparam int LEFM_NSRC      = 15;
	localparam logic [1:0] LEFM_RESP_OKAY   = 2'b00;
	localparam logic [1:0] LEFM_RESP_SLVERR = 2'b10;
endpackage : lefm_pkg

// File: verif/lefm_assertions.sv
/* Checker for the event flag unit: stuck state, summary output, bus holds.
   Bound into lefm_top and sees only its ports. */
`timescale 1ns/1ps
module lefm_assertions (
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// Stuck control and summary
	input wire logic        ev_async_underflow,
	input wire logic        ev_async_bad_first,
	input wire logic        async_tx_queue_clear,
	input wire logic        async_tx_stuck_state,
	input wire logic        async_tx_allow,
	input wire logic        irq,
	// Bus responses
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	wire stk_ev = ev_async_underflow | ev_async_bad_first;
	property p_allow; async_tx_allow == !async_tx_stuck_state; endproperty
	a_allow: assert property (p_allow) else $error("allow wrong");
	property p_set; stk_ev |=> async_tx_stuck_state; endproperty
	a_set: assert property (p_set) else $error("stuck not set");
	property p_hold; async_tx_stuck_state && !async_tx_queue_clear |=> async_tx_stuck_state;
	endproperty
	a_hold: assert property (p_hold) else $error("stuck lost");
	property p_rise; $rose(async_tx_stuck_state) |-> $past(stk_ev); endproperty
	a_rise: assert property (p_rise) else $error("stuck without cause");
	property p_fall; $fell(async_tx_stuck_state) |-> $past(async_tx_queue_clear); endproperty
	a_fall: assert property (p_fall) else $error("stuck freed early");
	// Clearing or masking only acts through a register write.
	property p_irq_fall;
		$fell(irq) |-> $rose(s_axi_bvalid) || ($past(s_axi_bvalid) && !$past(s_axi_bvalid, 2));
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data moved");
	c_irq: cover property ($rose(irq));
	c_stuck: cover property ($rose(async_tx_stuck_state));
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : lefm_assertions
bind lefm_top lefm_assertions i_chk (
	.clk                  (clk),
	.resetn               (resetn),
	.ev_async_underflow   (ev_async_underflow),
	.ev_async_bad_first   (ev_async_bad_first),
	.async_tx_queue_clear (async_tx_queue_clear),
	.async_tx_stuck_state (async_tx_stuck_state),
	.async_tx_allow       (async_tx_allow),
	.irq                  (irq),
	.s_axi_bvalid         (s_axi_bvalid),
	.s_axi_bready         (s_axi_bready),
	.s_axi_rvalid         (s_axi_rvalid),
	.s_axi_rready         (s_axi_rready),
	.s_axi_rdata          (s_axi_rdata)
);

// File: verif/lefm_link_model.sv
/* Link-side event source: one-cycle event pulses and the queue clear.
   Assumes clk is the unit's clock. */
`timescale 1ns/1ps
module lefm_link_model (
	// Clock
	input wire logic    clk,
	// Event lines and queue clear
	output logic [14:0] ev,
	output logic        qclr
);
	initial begin
		ev = 15'h0000;
		qclr = 1'b0;
	end
	task automatic pulse(input int i);
		@(posedge clk);
		ev <= 15'h0001 << i;
		@(posedge clk);
		ev <= 15'h0000;
	endtask : pulse
	task automatic clear_q();
		@(posedge clk);
		qclr <= 1'b1;
		@(posedge clk);
		qclr <= 1'b0;
	endtask : clear_q
endmodule : lefm_link_model

// File: verif/link_event_flag_mask_unit_tb.sv
/* Self-checking bench: AXI4-Lite register tasks and event pulses.
   Assumes the unit answers in its own time; only the watchdog ends a hang. */
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module link_event_flag_mask_unit_tb;
	logic        clk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        resetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, b;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        irq, async_tx_stuck_state, async_tx_allow, async_tx_queue_clear;
	logic [14:0] ev;
	int          fail_count = 0, compares = 0;
	int          pos [15] = '{1, 2, 3, 5, 6, 7, 9, 10, 11, 12, 12, 14, 15, 16, 19};
	lefm_link_model i_link (.clk(clk), .ev(ev), .qclr(async_tx_queue_clear));
	lefm_top i_dut (.*,
		.ev_phy_irq(ev[0]), .ev_phy_reg_rx(ev[1]), .ev_bus_reset(ev[2]), .ev_tx_idle(ev[3]),
		.ev_async_rx(ev[4]), .ev_reset_cmd(ev[5]), .ev_iso_rx(ev[6]), .ev_selfid_err(ev[7]),
		.ev_iso_tx_bad(ev[8]), .ev_async_underflow(ev[9]), .ev_async_bad_first(ev[10]),
		.ev_busy_ack(ev[11]), .ev_header_crc(ev[12]), .ev_bad_tcode(ev[13]),
		.ev_host_wr_err(ev[14]));
	task automatic test_done();
		if (fail_count == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : test_done
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		`CHK({s_axi_awvalid, s_axi_wvalid}, 2'b00)
		`CHK(s_axi_bresp, r)
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		`CHK(s_axi_arvalid, 1'b0)
		`CHK(s_axi_rdata, e)
		`CHK(s_axi_rresp, r)
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask : rd
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200_000;
		fail_count++;
		test_done();
	end
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		rd(8'h10, 32'h8000_1000, 2'b00);
		rd(8'h0C, 32'h0000_0000, 2'b00);
		for (int i = 0; i < 15; i++) begin
			b = 32'h8000_0000 >> pos[i];
			i_link.pulse(i);
			rd(8'h0C, b | (i == 14 ? 32'h8000_0000 : 32'h0000_0000), 2'b00);
			`CHK(irq, i == 14)
			if (pos[i] == 12) begin
				`CHK(async_tx_allow, 1'b0)
				`CHK(async_tx_stuck_state, 1'b1)
				rd(8'h40, 32'h8000_0000, 2'b00);
				i_link.clear_q();
				@(posedge clk);
				`CHK(async_tx_allow, 1'b1)
				`CHK(async_tx_stuck_state, 1'b0)
				rd(8'h40, 32'h0000_0000, 2'b00);
			end
			wr(8'h0C, b, 2'b00);
			rd(8'h0C, 32'h0000_0000, 2'b00);
		end
		i_link.pulse(0);
		i_link.pulse(13);
		wr(8'h0C, 32'h4000_0000, 2'b00);
		rd(8'h0C, 32'h0000_8000, 2'b00);
		wr(8'h10, 32'h8000_8000, 2'b00);
		rd(8'h10, 32'h8000_8000, 2'b00);
		`CHK(irq, 1'b1)
		rd(8'h0C, 32'h8000_8000, 2'b00);
		wr(8'h10, 32'h8000_0000, 2'b00);
		`CHK(irq, 1'b0)
		rd(8'h0C, 32'h0000_8000, 2'b00);
		wr(8'h20, 32'h8000_0000, 2'b00);
		rd(8'h20, 32'h8000_0000, 2'b00);
		wr(8'h0C, 32'hFFFF_FFFF, 2'b00);
		rd(8'h0C, 32'hF77B_9000, 2'b00);
		`CHK(irq, 1'b1)
		wr(8'h20, 32'h0000_0000, 2'b00);
		wr(8'h0C, 32'hFFFF_FFFF, 2'b00);
		rd(8'h0C, 32'h0000_0000, 2'b00);
		`CHK(irq, 1'b0)
		wr(8'h7C, 32'hFFFF_FFFF, 2'b10);
		rd(8'h7C, 32'h0000_0000, 2'b10);
		test_done();
	end
endmodule : link_event_flag_mask_unit_tb
